/* src/discrete_io_map.svh */
// Address map, bit positions and widths for the discrete I/O service block
`ifndef DISCRETE_IO_MAP_SVH
`define DISCRETE_IO_MAP_SVH

// ==========================================================
// Addresses
`define ADDR_W 12
`define ADDR_KEYBOARD_MARK 12'h004
`define ADDR_TIMER_SPACECRAFT 12'h006
`define ADDR_PLATFORM_OPTICS 12'h007
`define ADDR_OUT_BASE 12'h008
`define OUT_COUNT 5

// ==========================================================
// Word layout
`define WORD_W 16
`define WORD_ZERO 16'h0000
`define KEY_LSB 0
`define KEY_W 5
`define BLK_BIT 5
`define SYNC_BIT 6
`define UNMAN_LSB 10
`define UNMAN_W 3
`define MARK_LO 14
`define MARK_HI 15
`define SRC_W 15

`endif

/* src/discrete_io_pkg.sv */
// Types shared by the discrete I/O service block
package discrete_io_pkg;
	typedef struct packed {
		logic clear_control;
		logic read_control;
		logic write_control;
		logic [11:0] addr;
	} cpu_ctl_s;

	typedef struct packed {
		logic [4:0] keycode;
		logic key_strobe;
		logic mark;
		logic uplink_block_switch;
		logic uplink_sync_inhibit;
		logic [2:0] unmanned;
		logic keyboard_trap;
		logic mark_trap;
	} kbd_in_s;

	typedef enum logic [1:0] {
		SEL_NONE,
		SEL_KBD,
		SEL_TMR,
		SEL_OPT
	} in_sel_e;
endpackage

/* src/input_sync.sv */
// Two-stage synchroniser for a bank of pin inputs
`timescale 1ns/1ns
`default_nettype none
module input_sync #(
	parameter int W = 1
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] sync
);
	logic [W-1:0] meta_q;
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			meta_q <= '0;
			sync <= '0;
		end else begin
			meta_q <= pin;
			sync <= meta_q;
		end
	end
endmodule
`default_nettype wire

/* src/in_register.sv */
// One 16-bit input register: sources set bits, strobe clears
`timescale 1ns/1ns
`default_nettype none
`include "discrete_io_map.svh"
module in_register (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic clear,
	input wire logic [`SRC_W-1:0] src,
	output logic [`WORD_W-1:0] value
);
	wire [`WORD_W-1:0] set_w = {src[`SRC_W-1], src};
	always_ff @(posedge ref_clk) begin
		if (!rstn)
			value <= `WORD_ZERO;
		else if (clear)
			value <= `WORD_ZERO;
		else
			value <= value | set_w;
	end
endmodule
`default_nettype wire

/* src/discrete_io_register_service.sv */
// Discrete input registers and output register service logic
`timescale 1ns/1ns
`default_nettype none
`include "discrete_io_map.svh"
module discrete_io_register_service
	import discrete_io_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire discrete_io_pkg::cpu_ctl_s cpu,
	input wire logic [`WORD_W-1:0] write_lines_in,
	input wire discrete_io_pkg::kbd_in_s kbd,
	input wire logic [`SRC_W-1:0] timer_spacecraft_src,
	input wire logic [`SRC_W-1:0] platform_optics_src,
	input wire logic system_restart,
	output logic [`WORD_W-1:0] write_lines_out,
	output logic write_lines_valid,
	output logic [`OUT_COUNT*`WORD_W-1:0] out_regs
);
	import discrete_io_pkg::*;

	// ==========================================================
	// Pin synchronisers
	localparam int KW = $bits(kbd_in_s);
	kbd_in_s kbd_s;
	logic [`SRC_W-1:0] tmr_s;
	logic [`SRC_W-1:0] opt_s;
	logic restart_s;

	input_sync #(.W(KW)) u_sync_kbd (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.pin(kbd),
		.sync(kbd_s)
	);
	input_sync #(.W(`SRC_W)) u_sync_tmr (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.pin(timer_spacecraft_src),
		.sync(tmr_s)
	);
	input_sync #(.W(`SRC_W)) u_sync_opt (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.pin(platform_optics_src),
		.sync(opt_s)
	);
	input_sync #(.W(1)) u_sync_rst (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.pin(system_restart),
		.sync(restart_s)
	);

	wire [`KEY_W-1:0] keycode_w = kbd_s.keycode;
	wire key_strobe_w = kbd_s.key_strobe;
	wire mark_w = kbd_s.mark;
	wire blk_w = kbd_s.uplink_block_switch;
	wire sync_inh_w = kbd_s.uplink_sync_inhibit;
	wire [`UNMAN_W-1:0] unman_w = kbd_s.unmanned;
	wire ktrap_w = kbd_s.keyboard_trap;
	wire mtrap_w = kbd_s.mark_trap;

	// ==========================================================
	// Address decode
	function automatic logic hit(input logic [`ADDR_W-1:0] a,
		input logic [`ADDR_W-1:0] ref_a);
		hit = (a == ref_a);
	endfunction

	wire sel_kbd = hit(cpu.addr, `ADDR_KEYBOARD_MARK);
	wire sel_tmr = hit(cpu.addr, `ADDR_TIMER_SPACECRAFT);
	wire sel_opt = hit(cpu.addr, `ADDR_PLATFORM_OPTICS);

	// ==========================================================
	// Strobes
	wire trap_clear = ktrap_w | mtrap_w;
	wire first_input_clear = (sel_kbd & cpu.clear_control) | trap_clear;
	wire clr_tmr = sel_tmr & cpu.clear_control;
	wire clr_opt = sel_opt & cpu.clear_control;
	wire rd_kbd = sel_kbd & cpu.read_control;
	wire rd_tmr = sel_tmr & cpu.read_control;
	wire rd_opt = sel_opt & cpu.read_control;

	// Key and mark capture held off while a trap clear is active, so clear comes first
	wire cap_ok = ~trap_clear;

	// ==========================================================
	// First input register sources
	logic [`SRC_W-1:0] kbd_src;
	always_comb begin
		kbd_src = '0;
		if (cap_ok) begin
			if (key_strobe_w)
				kbd_src[`KEY_LSB +: `KEY_W] = keycode_w;
			kbd_src[`MARK_LO] = mark_w;
		end
		kbd_src[`BLK_BIT] = blk_w;
		kbd_src[`SYNC_BIT] = sync_inh_w;
		kbd_src[`UNMAN_LSB +: `UNMAN_W] = unman_w;
	end

	logic [`WORD_W-1:0] kbd_val;
	logic [`WORD_W-1:0] tmr_val;
	logic [`WORD_W-1:0] opt_val;

	in_register u_in_kbd (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.clear(first_input_clear),
		.src(kbd_src),
		.value(kbd_val)
	);
	in_register u_in_tmr (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.clear(clr_tmr),
		.src(tmr_s),
		.value(tmr_val)
	);
	in_register u_in_opt (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.clear(clr_opt),
		.src(opt_s),
		.value(opt_val)
	);

	// ==========================================================
	// Read path onto write lines
	in_sel_e sel_w;
	assign sel_w = rd_kbd ? SEL_KBD :
		rd_tmr ? SEL_TMR :
		rd_opt ? SEL_OPT : SEL_NONE;

	logic [`WORD_W-1:0] rd_data;
	always_comb begin
		case (sel_w)
			SEL_KBD: rd_data = kbd_val;
			SEL_TMR: rd_data = tmr_val;
			SEL_OPT: rd_data = opt_val;
			default: rd_data = `WORD_ZERO;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			write_lines_out <= `WORD_ZERO;
			write_lines_valid <= 1'b0;
		end else begin
			write_lines_out <= rd_data;
			write_lines_valid <= (sel_w != SEL_NONE);
		end
	end

	// ==========================================================
	// Output registers
	genvar gi;
	generate
		for (gi = 0; gi < `OUT_COUNT; gi++) begin : g_out
			localparam logic [`ADDR_W-1:0] OA =
				`ADDR_OUT_BASE + `ADDR_W'(gi);
			wire wr = hit(cpu.addr, OA) & cpu.write_control;
			wire clr = restart_s | (hit(cpu.addr, OA) & cpu.clear_control);
			always_ff @(posedge ref_clk) begin
				if (!rstn)
					out_regs[gi*`WORD_W +: `WORD_W] <= `WORD_ZERO;
				else if (clr)
					out_regs[gi*`WORD_W +: `WORD_W] <= `WORD_ZERO;
				else if (wr)
					out_regs[gi*`WORD_W +: `WORD_W] <= write_lines_in;
			end
		end
	endgenerate
endmodule
`default_nettype wire

/* verification/discrete_io_register_service_assertions.sv */
// Port checker for the discrete I/O register service block
`timescale 1ns/1ns
`default_nettype none
`include "discrete_io_map.svh"
module discrete_io_register_service_assertions
	import discrete_io_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire discrete_io_pkg::cpu_ctl_s cpu,
	input wire logic [`WORD_W-1:0] write_lines_in,
	input wire logic system_restart,
	input wire logic [`WORD_W-1:0] write_lines_out,
	input wire logic write_lines_valid,
	input wire logic [`OUT_COUNT*`WORD_W-1:0] out_regs
);
	// ========
	// Helpers
	logic [3:0] rs_q;
	logic hit;
	logic quiet;
	assign hit = cpu.addr == 12'h004 || cpu.addr == 12'h006 ||
		cpu.addr == 12'h007;
	assign quiet = rs_q == 4'h0 && !system_restart;
	always_ff @(posedge ref_clk) begin
		rs_q <= {rs_q[2:0], system_restart};
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// ========
	// Assertions
	a_read_strobe: assert property (cpu.read_control && hit |=>
		write_lines_valid) else $error("read not answered");
	a_read_cause: assert property (write_lines_valid |->
		$past(cpu.read_control && hit)) else $error("stray read");
	a_idle_zero: assert property (!write_lines_valid |->
		write_lines_out == 16'h0000) else $error("lines not idle");
	a_dup_msb: assert property (write_lines_valid |->
		write_lines_out[15] == write_lines_out[14]) else $error("msb");
	a_out_write: assert property (cpu.write_control &&
		!cpu.clear_control && cpu.addr == 12'h008 && quiet |=>
		out_regs[15:0] == $past(write_lines_in)) else $error("no load");
	a_out_hold: assert property (!cpu.write_control &&
		!cpu.clear_control && quiet |=> $stable(out_regs))
		else $error("out regs moved");
	a_restart_clear: assert property (system_restart [*2] |->
		##[1:3] out_regs == '0) else $error("restart missed");
	a_reset_quiet: assert property ($rose(rstn) |->
		out_regs == '0 && !write_lines_valid) else $error("reset");
	c_read: cover property (write_lines_valid && write_lines_out != 0);
	c_write: cover property (cpu.write_control && cpu.addr == 12'h00C);
	c_restart: cover property (system_restart [*2]);
endmodule
bind discrete_io_register_service discrete_io_register_service_assertions
	u_chk (.ref_clk, .rstn, .cpu, .write_lines_in, .system_restart,
	.write_lines_out, .write_lines_valid, .out_regs);
`default_nettype wire

/* verification/cpu_model.sv */
// Processor side: control pulses, address and write lines
`timescale 1ns/1ns
`default_nettype none
module cpu_model
	import discrete_io_pkg::*;
(
	input wire logic ref_clk,
	output var discrete_io_pkg::cpu_ctl_s cpu,
	output logic [15:0] write_lines_in
);
	initial begin
		cpu = '0;
		write_lines_in = 16'h0000;
	end
	// Control order: clear, read, write
	task xfer(input logic [2:0] ctl, input logic [11:0] a,
		input logic [15:0] d);
		@(posedge ref_clk);
		cpu <= {ctl, a};
		write_lines_in <= d;
		@(posedge ref_clk);
		cpu <= '0;
		write_lines_in <= ~d;
	endtask
endmodule
`default_nettype wire

/* verification/discrete_io_register_service_test.sv */
// Self-checking bench for the discrete I/O register service block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
	$display("[ERR] %0t got %h want %h", $time, (g), (e)); end end
module discrete_io_register_service_test;
	import discrete_io_pkg::*;
	logic ref_clk, rstn, system_restart, write_lines_valid;
	cpu_ctl_s cpu;
	kbd_in_s kbd;
	logic [15:0] write_lines_in, write_lines_out;
	logic [14:0] ts, po;
	logic [79:0] out_regs, exp_q;
	int miscompares = 0;
	int n_tests = 0;
	discrete_io_register_service u_discrete_io_register_service (
		.ref_clk, .rstn, .cpu, .write_lines_in, .kbd,
		.timer_spacecraft_src(ts), .platform_optics_src(po),
		.system_restart, .write_lines_out, .write_lines_valid, .out_regs);
	cpu_model u_cpu_model (.ref_clk, .cpu, .write_lines_in);
	initial begin
		ref_clk = 0;
		forever #5 ref_clk = ~ref_clk;
	end
	task report_and_stop;
		if (miscompares == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task rd(input logic [11:0] a, input logic [15:0] e, input logic v);
		u_cpu_model.xfer(3'b010, a, 16'h0000);
		#1;
		`CHK(write_lines_valid, v)
		`CHK(write_lines_out, e)
	endtask
	task trap(input logic mk);
		@(posedge ref_clk);
		kbd.keycode <= 5'h15;
		kbd.key_strobe <= !mk;
		kbd.mark <= mk;
		kbd.mark_trap <= mk;
		kbd.keyboard_trap <= !mk;
		repeat (2) @(posedge ref_clk);
		kbd.mark_trap <= 0;
		kbd.keyboard_trap <= 0;
		repeat (5) @(posedge ref_clk);
		kbd.key_strobe <= 0;
		kbd.mark <= 0;
	endtask
	initial begin
		repeat (3000) @(posedge ref_clk);
		miscompares++;
		report_and_stop;
	end
	initial begin
		rstn = 0;
		kbd = '0;
		ts = 15'h0000;
		po = 15'h0000;
		system_restart = 0;
		repeat (6) @(posedge ref_clk);
		rstn <= 1;
		for (int k = 0; k < 5; k++) begin
			exp_q[16*k +: 16] = 16'(16'h1111 * (k + 1));
			u_cpu_model.xfer(3'b001, 12'(12'h008 + k), exp_q[16*k +: 16]);
		end
		#1 `CHK(out_regs, exp_q)
		@(posedge ref_clk);
		system_restart <= 1;
		repeat (2) @(posedge ref_clk);
		system_restart <= 0;
		repeat (4) @(posedge ref_clk);
		#1 `CHK(out_regs, 80'h0)
		kbd.uplink_block_switch <= 1;
		kbd.uplink_sync_inhibit <= 1;
		kbd.unmanned <= 3'b101;
		kbd.mark <= 1;
		ts <= 15'h4001;
		po <= 15'h7FFF;
		repeat (4) @(posedge ref_clk);
		rd(12'h004, 16'hD460, 1);
		rd(12'h006, 16'hC001, 1);
		rd(12'h007, 16'hFFFF, 1);
		rd(12'h005, 16'h0000, 0);
		rd(12'h008, 16'h0000, 0);
		kbd <= '0;
		ts <= 15'h0000;
		repeat (4) @(posedge ref_clk);
		u_cpu_model.xfer(3'b100, 12'h006, 16'h0000);
		rd(12'h006, 16'h0000, 1);
		rd(12'h004, 16'hD460, 1);
		trap(0);
		rd(12'h004, 16'h0015, 1);
		trap(1);
		rd(12'h004, 16'hC000, 1);
		u_cpu_model.xfer(3'b100, 12'h004, 16'h0000);
		u_cpu_model.xfer(3'b001, 12'h004, 16'hFFFF);
		rd(12'h004, 16'h0000, 1);
		report_and_stop;
	end
endmodule
`default_nettype wire
